// ### verilog/fault_response_controller.sv
// Fault response controller: status latching, alert, shutdown and restart actions.
// ----------------------------------------------------------------
// Overview of operation
// - Overcurrent sets summary, word and current-status overcurrent bits.
// - Alert is raised for every set status bit not masked.
// - Overcurrent detections are ignored during rise and fall sequencing.
// - Response 0x keeps running; only hardware current limit acts.
// - Response 10 shuts down without restart after the fault persists the delay.
// - Response 11 shuts down at once and follows the retry field.
// - Retry 000 to 110 stays off until cleared, cycled off-on, or reset.
// - Retry 111 restarts endlessly spaced by the restart interval setting.
// - The overcurrent delay field counts in 16 ms steps.
// - Delay field reads back zero unless response field is 10.
// - Latched faults clear only on the listed clear events.
// - Unsupported overcurrent value raises a logic fault, setting unchanged.
// - External overtemperature sets temperature bits, applies its action byte.
// - Undertemperature sets temperature bits, applies its action byte.
// - Die overtemperature sets the manufacturer bits.
// - Die action disables above the hot point, restarts below the cool point.
// - Die action byte is read only.
// - Temperature action 00 runs, 10 shuts down and follows the retry field, others are refused.
// - Temperature action delay field is ignored.
// - Retry waits for fault gone and output decayed unless qualification off.
// ----------------------------------------------------------------
module fault_response_controller
    import fault_response_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        link_clk,
    input  wire logic        link_rst_n,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [7:0]  cmd_wdata,
    output logic      [7:0]  cmd_rdata,
    input  wire logic        clear_faults,
    input  wire logic        restore_user,
    input  wire logic        vendor_soft_reset_command,
    input  wire logic [4:0]  status_w1c,
    input  wire logic [4:0]  alert_mask,
    input  wire logic        decay_qual_off,
    input  wire logic [15:0] restart_interval_setting,
    input  wire logic        oc_detect,
    input  wire logic        ext_ot_detect,
    input  wire logic        ext_ut_detect,
    input  wire logic        die_above_off,
    input  wire logic        die_below_on,
    input  wire logic        seq_ramp,
    input  wire logic        out_decayed,
    input  wire logic        run_on,
    output logic             alert_n,
    output logic             out_enable,
    output logic             stat_byte_iout_oc,
    output logic             stat_byte_temp,
    output logic             stat_word_iout,
    output logic             stat_word_mfr,
    output logic             stat_iout_oc_fault,
    output logic             stat_temp_ot,
    output logic             stat_temp_ut,
    output logic             stat_mfr_ot,
    output logic             stat_cml
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]    sync1;
        logic [7:0]    sync2;
        logic          run_d;
        action_state_e fsm;
        logic          die_off;
        logic [4:0]    flags;
        logic [7:0]    oc_cfg;
        logic [7:0]    ot_cfg;
        logic [7:0]    ut_cfg;
        logic [15:0]   pre;
        logic [15:0]   ms;
        logic          enable;
        logic          alert_n;
        logic [7:0]    rdata;
    } ctrl_s;

    typedef struct packed {
        logic s1;
        logic s2;
    } link_s;

    ctrl_s st_reg, st_next;
    link_s lk_reg, lk_next;

    logic [7:0] pins;
    logic       oc_act, run_s, run_rise, host_clear, any_fault, qualified;
    logic       oc_trig, oc_persist_done, ot_trig, ut_trig, shut_any, shut_latch;
    logic [15:0] oc_limit;

    // Advances the millisecond timer: prescaler wraps once per millisecond.
    function automatic logic [31:0] timer_step(input logic [15:0] pre, input logic [15:0] ms);
        if (pre == 16'(TICK_CYC - 1))
            return {16'h0000, ms + 16'h0001};
        return {pre + 16'h0001, ms};
    endfunction

    // Only 00 and 10 are legal temperature responses.
    function automatic logic temp_ok(input logic [7:0] v);
        return v[RESP_HI:RESP_LO] == RESP_RUN || v[RESP_HI:RESP_LO] == TEMP_SHUT;
    endfunction

    assign pins = {run_on, out_decayed, seq_ramp, die_below_on, die_above_off,
                   ext_ut_detect, ext_ot_detect, oc_detect};

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = pins;
        st_next.sync2 = st_reg.sync1;

        // Sequencing intervals blank the overcurrent detector.
        oc_act     = st_reg.sync2[PIN_OC] && !st_reg.sync2[PIN_RAMP];
        run_s      = st_reg.sync2[PIN_RUN];
        run_rise   = run_s && !st_reg.run_d;
        host_clear = clear_faults || restore_user || vendor_soft_reset_command;
        st_next.run_d = run_s;

        // Clear events first, so a detection in the same cycle still wins.
        if (host_clear || run_rise)
            st_next.flags = 5'h00;
        st_next.flags = st_next.flags & ~status_w1c;
        if (oc_act)
            st_next.flags[FLG_OC] = 1'b1;
        if (st_reg.sync2[PIN_OT])
            st_next.flags[FLG_OT] = 1'b1;
        if (st_reg.sync2[PIN_UT])
            st_next.flags[FLG_UT] = 1'b1;
        if (st_reg.sync2[PIN_HOT])
            st_next.flags[FLG_DIE] = 1'b1;

        // Command writes; refused values leave the setting alone and flag a logic fault.
        if (cmd_valid && cmd_write) begin
            case (cmd_code)
                CMD_OC_ACTION: begin
                    if (cmd_wdata[RESP_HI:RESP_LO] == RESP_DELAYED &&
                        cmd_wdata[RETRY_HI:RETRY_LO] != 3'b000)
                        st_next.flags[FLG_CML] = 1'b1;
                    else
                        st_next.oc_cfg = cmd_wdata;
                end
                CMD_OT_ACTION: begin
                    if (temp_ok(cmd_wdata))
                        st_next.ot_cfg = {cmd_wdata[7:3], 3'b000};
                    else
                        st_next.flags[FLG_CML] = 1'b1;
                end
                CMD_UT_ACTION: begin
                    if (temp_ok(cmd_wdata))
                        st_next.ut_cfg = {cmd_wdata[7:3], 3'b000};
                    else
                        st_next.flags[FLG_CML] = 1'b1;
                end
                CMD_DIE_ACTION: st_next.flags[FLG_CML] = 1'b1;
                default: ;
            endcase
        end

        // Readback; the delay field hides unless the delayed response is selected.
        if (cmd_valid && !cmd_write) begin
            case (cmd_code)
                CMD_OC_ACTION: begin
                    st_next.rdata = st_reg.oc_cfg;
                    if (st_reg.oc_cfg[RESP_HI:RESP_LO] != RESP_DELAYED)
                        st_next.rdata[DELAY_HI:DELAY_LO] = 3'b000;
                end
                CMD_OT_ACTION:  st_next.rdata = st_reg.ot_cfg;
                CMD_UT_ACTION:  st_next.rdata = st_reg.ut_cfg;
                CMD_DIE_ACTION: st_next.rdata = DIE_ACT_RESET;
                default:        st_next.rdata = 8'h00;
            endcase
        end

        // Die temperature hysteresis is independent of the action machine.
        if (st_reg.sync2[PIN_HOT])
            st_next.die_off = 1'b1;
        else if (st_reg.sync2[PIN_COOL])
            st_next.die_off = 1'b0;

        // Shutdown triggers; response 0x never shuts down.
        oc_limit = 16'(st_reg.oc_cfg[DELAY_HI:DELAY_LO]) * 16'(OC_STEP_MS);
        oc_persist_done = st_reg.oc_cfg[RESP_HI:RESP_LO] == RESP_DELAYED && oc_act &&
                          st_reg.ms >= oc_limit;
        oc_trig  = oc_act && st_reg.oc_cfg[RESP_HI:RESP_LO] == RESP_SHUT;
        ot_trig  = st_reg.sync2[PIN_OT] && st_reg.ot_cfg[RESP_HI:RESP_LO] == TEMP_SHUT;
        ut_trig  = st_reg.sync2[PIN_UT] && st_reg.ut_cfg[RESP_HI:RESP_LO] == TEMP_SHUT;
        shut_any = oc_trig || oc_persist_done || ot_trig || ut_trig;
        // A trigger without endless retry forces a latched stop over any retrying one.
        shut_latch = oc_persist_done ||
            (oc_trig && st_reg.oc_cfg[RETRY_HI:RETRY_LO] != RETRY_FOREVER) ||
            (ot_trig && st_reg.ot_cfg[RETRY_HI:RETRY_LO] != RETRY_FOREVER) ||
            (ut_trig && st_reg.ut_cfg[RETRY_HI:RETRY_LO] != RETRY_FOREVER);
        any_fault = oc_act || st_reg.sync2[PIN_OT] || st_reg.sync2[PIN_UT];
        qualified = st_reg.sync2[PIN_DECAY] || decay_qual_off;

        // Action machine.
        case (st_reg.fsm)
            ST_RUN: begin
                if (shut_latch) begin
                    st_next.fsm = ST_LATCHED;
                end else if (shut_any) begin
                    st_next.fsm = ST_WAIT_GONE;
                end
                // Persistence timer runs only while the delayed-response fault holds.
                if (!shut_any && oc_act && st_reg.oc_cfg[RESP_HI:RESP_LO] == RESP_DELAYED)
                    {st_next.pre, st_next.ms} = timer_step(st_reg.pre, st_reg.ms);
                else
                    {st_next.pre, st_next.ms} = 32'h0000_0000;
            end
            ST_WAIT_GONE: begin
                {st_next.pre, st_next.ms} = 32'h0000_0000;
                if (shut_latch)
                    st_next.fsm = ST_LATCHED;
                else if (!any_fault && qualified)
                    st_next.fsm = ST_RETRY;
            end
            ST_RETRY: begin
                {st_next.pre, st_next.ms} = timer_step(st_reg.pre, st_reg.ms);
                if (shut_latch)
                    st_next.fsm = ST_LATCHED;
                else if (st_reg.ms >= restart_interval_setting)
                    st_next.fsm = ST_RUN;
            end
            ST_LATCHED: begin
                {st_next.pre, st_next.ms} = 32'h0000_0000;
                if (host_clear || (|status_w1c[FLG_UT:FLG_OC]))
                    st_next.fsm = ST_RUN;
            end
            default: st_next.fsm = ST_RUN;
        endcase

        // Commanded off resets the action machine so the next on starts fresh.
        if (!run_s) begin
            st_next.fsm = ST_RUN;
            {st_next.pre, st_next.ms} = 32'h0000_0000;
        end

        st_next.enable  = run_s && st_next.fsm == ST_RUN && !st_next.die_off;
        st_next.alert_n = !(|(st_next.flags & ~alert_mask));
    end

    // Control domain registers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg        <= '0;
            st_reg.fsm    <= ST_RUN;
            st_reg.oc_cfg <= OC_RESET;
            st_reg.ot_cfg <= OT_UT_RESET;
            st_reg.ut_cfg <= OT_UT_RESET;
            st_reg.alert_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Link domain: enable level crosses through two flip-flops
    // ----------------------------------------------------------------
    always_comb begin
        lk_next.s1 = st_reg.enable;
        lk_next.s2 = lk_reg.s1;
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n)
            lk_reg <= '0;
        else
            lk_reg <= lk_next;
    end

    assign out_enable         = lk_reg.s2;
    assign cmd_rdata          = st_reg.rdata;
    assign alert_n            = st_reg.alert_n;
    assign stat_byte_iout_oc  = st_reg.flags[FLG_OC];
    assign stat_word_iout     = st_reg.flags[FLG_OC];
    assign stat_iout_oc_fault = st_reg.flags[FLG_OC];
    assign stat_byte_temp     = st_reg.flags[FLG_OT] | st_reg.flags[FLG_UT];
    assign stat_temp_ot       = st_reg.flags[FLG_OT];
    assign stat_temp_ut       = st_reg.flags[FLG_UT];
    assign stat_word_mfr      = st_reg.flags[FLG_DIE];
    assign stat_mfr_ot        = st_reg.flags[FLG_DIE];
    assign stat_cml           = st_reg.flags[FLG_CML];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_oc_drop;
        oc_act ##1 !oc_act;
    endsequence

    sequence s_bad_ot_write;
        cmd_valid && cmd_write && cmd_code == CMD_OT_ACTION && !temp_ok(cmd_wdata);
    endsequence

    a_oc_status_set: assert property (@(posedge clk) disable iff (!rst_n)
        oc_act |=> stat_byte_iout_oc && stat_word_iout && stat_iout_oc_fault)
        else $error("overcurrent status bits not set");

    a_alert_gating: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 alert_n == !(|($past(st_next.flags) & ~$past(alert_mask))))
        else $error("alert does not follow unmasked flags");

    a_ramp_blanks_oc: assert property (@(posedge clk) disable iff (!rst_n)
        (st_reg.sync2[PIN_RAMP] && !stat_iout_oc_fault && status_w1c == 5'h00)
        |=> !stat_iout_oc_fault)
        else $error("overcurrent flagged during sequencing");

    a_run_response: assert property (@(posedge clk) disable iff (!rst_n)
        (st_reg.fsm == ST_RUN && run_s && !st_reg.oc_cfg[RESP_HI] && !ot_trig && !ut_trig)
        |=> st_reg.fsm == ST_RUN)
        else $error("response 0x left the running state");

    a_immediate_shut: assert property (@(posedge clk) disable iff (!rst_n)
        (st_reg.fsm == ST_RUN && run_s && oc_trig) |=> st_reg.fsm != ST_RUN ##2 !out_enable)
        else $error("response 11 did not shut down");

    a_latched_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (st_reg.fsm == ST_LATCHED && run_s && !host_clear && status_w1c == 5'h00)
        |=> st_reg.fsm == ST_LATCHED)
        else $error("latched shutdown released without a clear event");

    a_persist_restart: assert property (@(posedge clk) disable iff (!rst_n)
        (st_reg.fsm == ST_RUN && run_s) ##0 s_oc_drop |=> st_reg.ms == 16'h0000)
        else $error("persistence timer kept its count after the fault dropped");

    a_delay_readback: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && !cmd_write && cmd_code == CMD_OC_ACTION &&
         st_reg.oc_cfg[RESP_HI:RESP_LO] != RESP_DELAYED) |=> cmd_rdata[DELAY_HI:DELAY_LO] == 3'b000)
        else $error("delay field visible with response other than 10");

    a_temp_refused: assert property (@(posedge clk) disable iff (!rst_n)
        s_bad_ot_write |=> stat_cml && $stable(st_reg.ot_cfg))
        else $error("unsupported temperature response accepted");

    a_die_disable: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg.sync2[PIN_HOT] |=> !st_reg.enable ##1 !st_reg.enable)
        else $error("output enabled while die too hot");

endmodule // fault_response_controller

// ### verilog/fault_response_pkg.sv
// Constants, command codes, field layouts and state encodings of the fault response controller.
package fault_response_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned TICK_TIME_MS = 1;
    localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_TIME_MS;
    localparam int unsigned OC_STEP_MS   = 16;

    // ----------------------------------------------------------------
    // Command codes and values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_OC_ACTION  = 8'he0;
    localparam logic [7:0] CMD_OT_ACTION  = 8'h50;
    localparam logic [7:0] CMD_UT_ACTION  = 8'h54;
    localparam logic [7:0] CMD_DIE_ACTION = 8'hd6;
    localparam logic [7:0] OC_RESET       = 8'h00;
    localparam logic [7:0] OT_UT_RESET    = 8'hb8;
    localparam logic [7:0] DIE_ACT_RESET  = 8'hc0;

    // ----------------------------------------------------------------
    // Action byte fields and values
    // ----------------------------------------------------------------
    localparam int unsigned RESP_HI  = 7;
    localparam int unsigned RESP_LO  = 6;
    localparam int unsigned RETRY_HI = 5;
    localparam int unsigned RETRY_LO = 3;
    localparam int unsigned DELAY_HI = 2;
    localparam int unsigned DELAY_LO = 0;
    localparam logic [1:0] RESP_DELAYED  = 2'b10;
    localparam logic [1:0] RESP_SHUT     = 2'b11;
    localparam logic [1:0] RESP_RUN      = 2'b00;
    localparam logic [1:0] TEMP_SHUT     = 2'b10;
    localparam logic [2:0] RETRY_FOREVER = 3'b111;

    // ----------------------------------------------------------------
    // Pin vector and status flag positions
    // ----------------------------------------------------------------
    localparam int unsigned PIN_OC    = 0;
    localparam int unsigned PIN_OT    = 1;
    localparam int unsigned PIN_UT    = 2;
    localparam int unsigned PIN_HOT   = 3;
    localparam int unsigned PIN_COOL  = 4;
    localparam int unsigned PIN_RAMP  = 5;
    localparam int unsigned PIN_DECAY = 6;
    localparam int unsigned PIN_RUN   = 7;
    localparam int unsigned FLG_OC    = 0;
    localparam int unsigned FLG_OT    = 1;
    localparam int unsigned FLG_UT    = 2;
    localparam int unsigned FLG_DIE   = 3;
    localparam int unsigned FLG_CML   = 4;

    typedef enum logic [1:0] {
        ST_RUN       = 2'b00,
        ST_WAIT_GONE = 2'b01,
        ST_RETRY     = 2'b11,
        ST_LATCHED   = 2'b10
    } action_state_e;

endpackage

// ### tb/fault_host_model.sv
// Host side model that issues single-byte fault configuration commands.
module fault_host_model (
    input  wire logic       clk,
    output logic            cmd_valid,
    output logic            cmd_write,
    output logic      [7:0] cmd_code,
    output logic      [7:0] cmd_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // The bus starts idle so nothing is taken before the first command.
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 8'h00;
    end

    // One command per clock; the strobe stays up so commands can run back to back.
    task automatic send(input logic wr, input logic [7:0] code, input logic [7:0] data);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code  = code;
        cmd_wdata = data;
        @(posedge clk);
        #2;
    endtask

    // Released qualifiers are scrambled so a stale byte never looks valid.
    task automatic idle();
        cmd_valid = 1'b0;
        cmd_code  = ~cmd_code;
        cmd_wdata = ~cmd_wdata;
    endtask
endmodule // fault_host_model

// ### tb/fault_response_controller_tb.sv
// Self-checking bench of the fault response controller driven by a host model.
module fault_response_controller_tb import fault_response_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, link_rst_n = 1'b0;
    logic        cmd_valid, cmd_write, alert_n, out_enable, rd_pend = 1'b0;
    logic [7:0]  cmd_code, cmd_wdata, cmd_rdata, v, exp_q[$];
    logic [2:0]  clr_v = 3'h0;
    logic [4:0]  status_w1c = 5'h00, alert_mask = 5'h00;
    logic        oc = 1'b0, ot = 1'b0, ut = 1'b0, hot = 1'b0, cool = 1'b1;
    logic        ramp = 1'b0, decayed = 1'b1, run_on = 1'b1, qual_off = 1'b0;
    logic        s_bo, s_bt, s_wi, s_wm, s_io, s_to, s_tu, s_mo, s_cml;
    logic [7:0]  obs;
    int          errors = 0, checked = 0, cycles = 0;

    // Short ticks keep the 16 ms steps at a few dozen cycles.
    localparam int unsigned TK = 4;

    always #12.5 clk = ~clk;
    initial #1 forever #3 link_clk = ~link_clk;

    fault_host_model fault_host_model_inst (.clk(clk), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

    fault_response_controller #(.TICK_CYC(TK)) fault_response_controller_inst (
        .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .link_rst_n(link_rst_n),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .clear_faults(clr_v[0]),
        .restore_user(clr_v[1]), .vendor_soft_reset_command(clr_v[2]),
        .status_w1c(status_w1c), .alert_mask(alert_mask), .decay_qual_off(qual_off),
        .restart_interval_setting(16'h0004), .oc_detect(oc), .ext_ot_detect(ot),
        .ext_ut_detect(ut), .die_above_off(hot), .die_below_on(cool), .seq_ramp(ramp),
        .out_decayed(decayed), .run_on(run_on), .alert_n(alert_n), .out_enable(out_enable),
        .stat_byte_iout_oc(s_bo), .stat_byte_temp(s_bt), .stat_word_iout(s_wi),
        .stat_word_mfr(s_wm), .stat_iout_oc_fault(s_io), .stat_temp_ot(s_to),
        .stat_temp_ut(s_tu), .stat_mfr_ot(s_mo), .stat_cml(s_cml));

    // Port summary; grouped status copies are ANDed so a missing copy reads as clear.
    assign obs = {out_enable, alert_n, s_cml, s_wm & s_mo, s_tu, s_to, s_bt, s_bo & s_wi & s_io};

    // ----------------------------------------------------------------
    // Checking
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic test_done();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Read data is judged in the cycle after the read is taken, against the oldest note.
    always @(posedge clk) rd_pend <= cmd_valid && !cmd_write;
    always @(negedge clk) begin
        if (rd_pend) begin
            check(cmd_rdata, exp_q.pop_front());
        end
    end

    // A hang is cut short well past the roughly 820 cycles the sequence needs.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // Stimulus helpers
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic rd(input logic [7:0] code, input logic [7:0] want);
        exp_q.push_back(want);
        fault_host_model_inst.send(1'b0, code, 8'h00);
    endtask

    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        fault_host_model_inst.send(1'b1, code, data);
    endtask

    task automatic clr(input logic [2:0] c, input logic [4:0] w);
        clr_v = c;
        status_w1c = w;
        cyc(1);
        clr_v = 3'h0;
        status_w1c = 5'h00;
        cyc(12);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h269320c6));
        cyc(16);
        rst_n = 1'b1;
        link_rst_n = 1'b1;
        cyc(20);
        check(obs, 8'hc0);
        rd(CMD_OC_ACTION, OC_RESET);
        rd(CMD_OT_ACTION, OT_UT_RESET);
        rd(CMD_UT_ACTION, OT_UT_RESET);
        rd(CMD_DIE_ACTION, DIE_ACT_RESET);
        rd(8'h00, 8'h00);
        // Random accepted settings outside response 10 must read back with no delay bits.
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            if (v[7:6] == RESP_DELAYED) v[6] = 1'b1;
            wr(CMD_OC_ACTION, v);
            rd(CMD_OC_ACTION, {v[7:3], 3'b000});
        end
        wr(CMD_OC_ACTION, 8'h81);
        rd(CMD_OC_ACTION, 8'h81);
        wr(CMD_OC_ACTION, 8'h90);
        rd(CMD_OC_ACTION, 8'h81);
        wr(CMD_DIE_ACTION, 8'h80);
        rd(CMD_DIE_ACTION, 8'hc0);
        wr(CMD_OT_ACTION, 8'h40);
        rd(CMD_OT_ACTION, 8'hb8);
        wr(CMD_OT_ACTION, 8'h87);
        rd(CMD_OT_ACTION, 8'h80);
        fault_host_model_inst.idle();
        cyc(2);
        check(obs, 8'ha0);
        clr(3'h0, 5'h10);
        // Delayed shutdown: 16 ticks per step; an early drop restarts the count.
        oc = 1'b1;
        cyc(50);
        oc = 1'b0;
        cyc(30);
        check(obs, 8'h81);
        oc = 1'b1;
        cyc(55);
        check(obs, 8'h81);
        cyc(30);
        check(obs, 8'h01);
        oc = 1'b0;
        cyc(40);
        check(obs, 8'h01);
        run_on = 1'b0;
        cyc(10);
        run_on = 1'b1;
        cyc(20);
        check(obs, 8'hc0);
        // Each host clear command, and status_w1c bit 0, on its own wipes a latched overcurrent flag.
        wr(CMD_OC_ACTION, 8'h00);
        fault_host_model_inst.idle();
        for (int k = 0; k < 4; k++) begin
            oc = 1'b1;
            cyc(8);
            oc = 1'b0;
            cyc(4);
            check(obs, 8'h81);
            clr((k < 3) ? 3'(1 << k) : 3'h0, (k == 3) ? 5'h01 : 5'h00);
            check(obs, 8'hc0);
        end
        alert_mask = 5'h01;
        oc = 1'b1;
        cyc(8);
        oc = 1'b0;
        // Let the detector drain through the synchroniser, or it sets the flag after the clear.
        cyc(4);
        check(obs, 8'hc1);
        clr(3'h0, 5'h01);
        alert_mask = 5'h00;
        ramp = 1'b1;
        cyc(4);
        oc = 1'b1;
        cyc(10);
        check(obs, 8'hc0);
        oc = 1'b0;
        cyc(4);
        ramp = 1'b0;
        // Immediate shutdown with no retry stays off until a clear event.
        wr(CMD_OC_ACTION, 8'hc0);
        fault_host_model_inst.idle();
        oc = 1'b1;
        cyc(14);
        check(obs, 8'h01);
        oc = 1'b0;
        cyc(40);
        check(obs, 8'h01);
        clr(3'h0, 5'h01);
        check(obs, 8'hc0);
        ot = 1'b1;
        cyc(14);
        ot = 1'b0;
        cyc(4);
        check(obs, 8'h06);
        clr(3'h0, 5'h02);
        check(obs, 8'hc0);
        // Undertemperature at its reset action retries only after decay.
        decayed = 1'b0;
        ut = 1'b1;
        cyc(14);
        ut = 1'b0;
        check(obs, 8'h0a);
        cyc(60);
        check(obs, 8'h0a);
        decayed = 1'b1;
        cyc(50);
        check(obs, 8'h8a);
        // With decay qualification off the retry no longer waits for the output to decay.
        qual_off = 1'b1;
        decayed = 1'b0;
        ut = 1'b1;
        cyc(14);
        ut = 1'b0;
        check(obs, 8'h0a);
        cyc(50);
        check(obs, 8'h8a);
        decayed = 1'b1;
        qual_off = 1'b0;
        clr(3'h0, 5'h04);
        hot = 1'b1;
        cool = 1'b0;
        cyc(14);
        check(obs, 8'h10);
        hot = 1'b0;
        cyc(20);
        check(obs, 8'h10);
        cool = 1'b1;
        cyc(20);
        check(obs, 8'h90);
        clr(3'h0, 5'h08);
        check(obs, 8'hc0);
        test_done();
    end
endmodule // fault_response_controller_tb
